/* File: rtl/tca_params.svh */
`ifndef TCA_PARAMS_SVH
`define TCA_PARAMS_SVH
// I/O offsets; data-space address adds the data offset
`define TCA_DATA_OFS 8'h20
`define TCA_SFIO_OFS 8'h20
`define TCA_ASTAT_OFS 8'h30
`define TCA_CMP_OFS 8'h31
`define TCA_CNT_OFS 8'h32
`define TCA_CTRL_OFS 8'h33
`define TCA_FLAG_OFS 8'h36
`define TCA_MASK_OFS 8'h37
// Field positions
`define TCA_ASYNC_BIT 3
`define TCA_CNT_UB_BIT 2
`define TCA_CMP_UB_BIT 1
`define TCA_CTRL_UB_BIT 0
`define TCA_CMP_BIT 1
`define TCA_OVF_BIT 0
`define TCA_HALT_BIT 7
`define TCA_PSR_BIT 1
`define TCA_WGM0_BIT 6
`define TCA_WGM1_BIT 3
// Reset values
`define TCA_REG_RST 8'h00
// Prescaler reset countdown, in ref_clk cycles; hold lasts one cycle more
`define TCA_PSR_CYCLES 2
`endif

/* File: rtl/tca_pkg.sv */
package tca_pkg;
  typedef struct packed {
    logic ioWr;
    logic ioRd;
    logic dataSpace;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tca_bus_t;
  typedef enum logic [1:0] {
    TCA_XF_IDLE = 2'b00,
    TCA_XF_REQ = 2'b01,
    TCA_XF_ACK = 2'b11
  } tca_xfer_t;
endpackage

/* File: rtl/tca_timer_regs.sv */
`timescale 1ns/1ps
`include "tca_params.svh"
module tca_timer_regs
  import tca_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input tca_pkg::tca_bus_t bus,
  output logic [7:0] rdata,
  input wire logic timer_osc_input,
  input wire logic timerTick,
  input wire logic globalIrqEnable,
  input wire logic compareVectorAck,
  input wire logic overflowVectorAck,
  output logic compareIrq,
  output logic overflowIrq,
  output logic compareMatch,
  output logic prescalerResetOut,
  output logic timerHalted,
  output logic [7:0] counterValue
);
  import tca_pkg::*;

  localparam logic [7:0] RST = `TCA_REG_RST;

  logic [7:0] cnt_q, cmpLive_q, ctrlLive_q, cmpTmp_q, ctrlTmp_q, cntTmp_q, mask_q;
  logic async_q, halt_q, psr_q, block_q, dirDown_q, cmpFlag_q, ovfFlag_q;
  logic [2:0] ub_q;
  logic [1:0] psrCnt_q;
  logic osc1_q, osc2_q, osc3_q;
  logic [2:0] ackMeta_q, ack_q;
  tca_xfer_t xfer_q [3];

  ////////////////////////////////////////////////////////////////////////
  // Address decode: I/O space or data space
  function automatic logic hit(input tca_bus_t b, input logic [7:0] ofs);
    logic [7:0] a;
    a = b.dataSpace ? 8'(b.addr - `TCA_DATA_OFS) : b.addr;
    return a == ofs;
  endfunction

  logic wrCnt, wrCmp, wrCtrl, wrFlag, wrMask, wrAst, wrSf;
  assign wrCnt = bus.ioWr && hit(bus, `TCA_CNT_OFS);
  assign wrCmp = bus.ioWr && hit(bus, `TCA_CMP_OFS);
  assign wrCtrl = bus.ioWr && hit(bus, `TCA_CTRL_OFS);
  assign wrFlag = bus.ioWr && hit(bus, `TCA_FLAG_OFS);
  assign wrMask = bus.ioWr && hit(bus, `TCA_MASK_OFS);
  assign wrAst = bus.ioWr && hit(bus, `TCA_ASTAT_OFS);
  assign wrSf = bus.ioWr && hit(bus, `TCA_SFIO_OFS);

  ////////////////////////////////////////////////////////////////////////
  // Crystal input synchronizer; edge seen only past second stage
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      osc1_q <= 1'b0;
      osc2_q <= 1'b0;
      osc3_q <= 1'b0;
    end
    else
    begin
      osc1_q <= timer_osc_input;
      osc2_q <= osc1_q;
      osc3_q <= osc2_q;
    end
  end

  logic oscEdge, tick;
  assign oscEdge = osc2_q && !osc3_q;
  // Crystal edges clock the counter in async mode
  assign tick = (async_q ? oscEdge : timerTick) && !halt_q && !psr_q;

  ////////////////////////////////////////////////////////////////////////
  // Async transfer handshake: request, applied on crystal edge, ack synced back
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < 3; i++)
        xfer_q[i] <= TCA_XF_IDLE;
      ackMeta_q <= 3'h0;
      ack_q <= 3'h0;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        case (xfer_q[i])
          TCA_XF_IDLE:
            if (ub_q[i] && !ack_q[i])
              xfer_q[i] <= TCA_XF_REQ;
          TCA_XF_REQ:
            if (oscEdge)
              xfer_q[i] <= TCA_XF_ACK;
          default:
            if (ack_q[i])
              xfer_q[i] <= TCA_XF_IDLE;
        endcase
        ackMeta_q[i] <= (xfer_q[i] == TCA_XF_ACK);
        ack_q[i] <= ackMeta_q[i];
      end
    end
  end

  logic [2:0] applyNow;
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      applyNow[i] = async_q ? (xfer_q[i] == TCA_XF_REQ && oscEdge) : 1'b0;
  end

  // Busy flags: write sets, confirmed ack clears; set wins
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ub_q <= 3'h0;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
        if (ack_q[i] && xfer_q[i] == TCA_XF_ACK)
          ub_q[i] <= 1'b0;
      if (async_q && wrCnt)
        ub_q[`TCA_CNT_UB_BIT] <= 1'b1;
      if (async_q && wrCmp)
        ub_q[`TCA_CMP_UB_BIT] <= 1'b1;
      if (async_q && wrCtrl)
        ub_q[`TCA_CTRL_UB_BIT] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Temporaries and live compare/control
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cmpTmp_q <= RST;
      ctrlTmp_q <= RST;
      cntTmp_q <= RST;
      cmpLive_q <= RST;
      ctrlLive_q <= RST;
    end
    else
    begin
      if (wrCmp)
        cmpTmp_q <= bus.wdata;
      if (wrCtrl)
        ctrlTmp_q <= bus.wdata;
      if (wrCnt)
        cntTmp_q <= bus.wdata;
      if (!async_q ? wrCmp : applyNow[`TCA_CMP_UB_BIT])
        cmpLive_q <= async_q ? cmpTmp_q : bus.wdata;
      if (!async_q ? wrCtrl : applyNow[`TCA_CTRL_UB_BIT])
        ctrlLive_q <= async_q ? ctrlTmp_q : bus.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter, direction, match blocking
  logic phaseCorrect, cntLoad;
  logic [7:0] cntLoadVal;
  assign phaseCorrect = ctrlLive_q[`TCA_WGM0_BIT] && !ctrlLive_q[`TCA_WGM1_BIT];
  assign cntLoad = async_q ? applyNow[`TCA_CNT_UB_BIT] : wrCnt;
  assign cntLoadVal = async_q ? cntTmp_q : bus.wdata;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cnt_q <= RST;
      dirDown_q <= 1'b0;
      block_q <= 1'b0;
    end
    else
    begin
      if (cntLoad)
      begin
        cnt_q <= cntLoadVal;
        block_q <= 1'b1;
      end
      else if (tick)
      begin
        block_q <= 1'b0;
        if (phaseCorrect)
        begin
          if (dirDown_q && cnt_q == 8'h00)
          begin
            dirDown_q <= 1'b0;
            cnt_q <= 8'h01;
          end
          else if (!dirDown_q && cnt_q == 8'hFF)
          begin
            dirDown_q <= 1'b1;
            cnt_q <= 8'hFE;
          end
          else
            cnt_q <= dirDown_q ? 8'(cnt_q - 8'h01) : 8'(cnt_q + 8'h01);
        end
        else
        begin
          dirDown_q <= 1'b0;
          cnt_q <= 8'(cnt_q + 8'h01);
        end
      end
    end
  end

  logic matchEv, ovfEv;
  // A write-blocked tick yields no match
  assign matchEv = tick && !block_q && !cntLoad && cnt_q == cmpLive_q;
  assign ovfEv = tick && !cntLoad &&
    (phaseCorrect ? (dirDown_q && cnt_q == 8'h00) : cnt_q == 8'hFF);

  ////////////////////////////////////////////////////////////////////////
  // Flags: event set wins over clear
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cmpFlag_q <= 1'b0;
      ovfFlag_q <= 1'b0;
      mask_q <= RST;
    end
    else
    begin
      if (wrMask)
        mask_q <= bus.wdata;
      if (matchEv)
        cmpFlag_q <= 1'b1;
      else if (compareVectorAck || (wrFlag && bus.wdata[`TCA_CMP_BIT]))
        cmpFlag_q <= 1'b0;
      if (ovfEv)
        ovfFlag_q <= 1'b1;
      else if (overflowVectorAck || (wrFlag && bus.wdata[`TCA_OVF_BIT]))
        ovfFlag_q <= 1'b0;
    end
  end

  assign compareIrq = globalIrqEnable && mask_q[`TCA_CMP_BIT] && cmpFlag_q;
  assign overflowIrq = globalIrqEnable && mask_q[`TCA_OVF_BIT] && ovfFlag_q;

  ////////////////////////////////////////////////////////////////////////
  // Async select, halt and prescaler reset
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      async_q <= 1'b0;
      halt_q <= 1'b0;
      psr_q <= 1'b0;
      psrCnt_q <= 2'h0;
    end
    else
    begin
      if (wrAst)
        async_q <= bus.wdata[`TCA_ASYNC_BIT];
      if (wrSf)
        halt_q <= bus.wdata[`TCA_HALT_BIT];
      if (wrSf && bus.wdata[`TCA_PSR_BIT])
      begin
        psr_q <= 1'b1;
        psrCnt_q <= 2'(`TCA_PSR_CYCLES);
      end
      else if (wrSf && !bus.wdata[`TCA_HALT_BIT])
      begin
        psr_q <= 1'b0;
        psrCnt_q <= 2'h0;
      end
      else if (!halt_q && psr_q)
      begin
        // Async reset needs a few cycles to complete
        if (psrCnt_q != 2'h0)
          psrCnt_q <= 2'(psrCnt_q - 2'h1);
        else
          psr_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb
  begin
    rdata = 8'h00;
    if (hit(bus, `TCA_CNT_OFS))
      rdata = cnt_q;
    else if (hit(bus, `TCA_CMP_OFS))
      rdata = cmpTmp_q;
    else if (hit(bus, `TCA_CTRL_OFS))
      rdata = {1'b0, ctrlTmp_q[6:0]};
    else if (hit(bus, `TCA_ASTAT_OFS))
      rdata = {4'h0, async_q, ub_q};
    else if (hit(bus, `TCA_FLAG_OFS))
      rdata = {6'h00, cmpFlag_q, ovfFlag_q};
    else if (hit(bus, `TCA_MASK_OFS))
      rdata = mask_q;
    else if (hit(bus, `TCA_SFIO_OFS))
      rdata = {halt_q, 5'h00, psr_q && async_q, 1'b0};
  end

  assign compareMatch = matchEv;
  assign prescalerResetOut = psr_q || halt_q;
  assign timerHalted = halt_q || psr_q;
  assign counterValue = cnt_q;
endmodule

/* File: verification/tca_timer_regs_sva.sv */
`timescale 1ns/1ps
`include "tca_params.svh"
module tca_timer_regs_sva
  import tca_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input tca_pkg::tca_bus_t bus,
  input wire logic [7:0] rdata,
  input wire logic timer_osc_input,
  input wire logic timerTick,
  input wire logic globalIrqEnable,
  input wire logic compareVectorAck,
  input wire logic overflowVectorAck,
  input wire logic compareIrq,
  input wire logic overflowIrq,
  input wire logic compareMatch,
  input wire logic prescalerResetOut,
  input wire logic timerHalted,
  input wire logic [7:0] counterValue
);
  import tca_pkg::*;
  logic asyncSel_q;
  logic halt_q;
  logic wrCnt;
  logic wrSfio;
  function automatic logic at(input logic [7:0] ofs);
    return bus.dataSpace ? (bus.addr == ofs + `TCA_DATA_OFS) : (bus.addr == ofs);
  endfunction
  assign wrCnt = bus.ioWr && at(`TCA_CNT_OFS);
  assign wrSfio = bus.ioWr && at(`TCA_SFIO_OFS);
  // Shadow of the mode bits, so sync-only relations can be gated
  always_ff @(posedge ref_clk)
  begin
    if (srst) asyncSel_q <= 1'b0;
    else if (bus.ioWr && at(`TCA_ASTAT_OFS)) asyncSel_q <= bus.wdata[`TCA_ASYNC_BIT];
  end
  always_ff @(posedge ref_clk)
  begin
    if (srst) halt_q <= 1'b0;
    else if (wrSfio) halt_q <= bus.wdata[`TCA_HALT_BIT];
  end
  ////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence cntWrAsync; wrCnt && asyncSel_q; endsequence
  sequence astatRead; !bus.ioWr && at(`TCA_ASTAT_OFS); endsequence
  cnt_load_a: assert property (wrCnt && !asyncSel_q |=> counterValue == $past(bus.wdata))
    else $error("counter write not loaded");
  match_block_a: assert property (wrCnt && !asyncSel_q |=> !compareMatch)
    else $error("match after counter write");
  match_tick_a: assert property (compareMatch && !asyncSel_q |-> timerTick)
    else $error("match without tick");
  cmp_irq_a: assert property (compareIrq |-> globalIrqEnable)
    else $error("compare irq without global enable");
  ovf_irq_a: assert property (overflowIrq |-> globalIrqEnable)
    else $error("overflow irq without global enable");
  cmp_ack_a: assert property (compareVectorAck && !compareMatch |=> !compareIrq)
    else $error("compare flag kept after vector");
  ovf_ack_a: assert property (overflowVectorAck && !timerTick && !asyncSel_q |=> !overflowIrq)
    else $error("overflow flag kept after vector");
  cnt_busy_a: assert property (cntWrAsync ##[1:3] astatRead |-> rdata[`TCA_CNT_UB_BIT])
    else $error("counter busy not set");
  psr_sync_a: assert property (!asyncSel_q && at(`TCA_SFIO_OFS) |-> !rdata[`TCA_PSR_BIT])
    else $error("prescaler reset read as one");
  psr_clear_a: assert property ($rose(prescalerResetOut) && !halt_q |-> ##[1:4] !prescalerResetOut)
    else $error("prescaler reset stuck");
  psr_hold_a: assert property (halt_q && prescalerResetOut && !wrSfio |=> prescalerResetOut)
    else $error("prescaler reset dropped in halt");
  halt_stop_a: assert property (timerHalted && !wrCnt |=> $stable(counterValue))
    else $error("counter moved while halted");
endmodule
bind tca_timer_regs tca_timer_regs_sva u_sva (.ref_clk(ref_clk), .srst(srst), .bus(bus),
  .rdata(rdata), .timer_osc_input(timer_osc_input), .timerTick(timerTick),
  .globalIrqEnable(globalIrqEnable), .compareVectorAck(compareVectorAck),
  .overflowVectorAck(overflowVectorAck), .compareIrq(compareIrq), .overflowIrq(overflowIrq),
  .compareMatch(compareMatch), .prescalerResetOut(prescalerResetOut),
  .timerHalted(timerHalted), .counterValue(counterValue));

/* File: verification/timer0_async_register_interface_bench.sv */
`timescale 1ns/1ps
`include "tca_params.svh"
`define CHK(n, e, g) begin totalChecks++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module timer0_async_register_interface_bench;
  import tca_pkg::*;
  logic ref_clk, srst, osc, tick, gie, cAck, oAck, cIrq, oIrq, cMatch, psrOut, halted, m;
  tca_bus_t bus;
  logic [7:0] rdata, cnt;
  int errors, totalChecks;
  tca_timer_regs DUT (.ref_clk(ref_clk), .srst(srst), .bus(bus), .rdata(rdata),
    .timer_osc_input(osc), .timerTick(tick), .globalIrqEnable(gie), .compareVectorAck(cAck),
    .overflowVectorAck(oAck), .compareIrq(cIrq), .overflowIrq(oIrq), .compareMatch(cMatch),
    .prescalerResetOut(psrOut), .timerHalted(halted), .counterValue(cnt));
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic endSim();
    $display("checks %0d errors %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    // Address space chosen by the caller stays in force
    bus = '{ioWr: 1'b1, ioRd: 1'b0, dataSpace: bus.dataSpace, addr: a, wdata: d};
    @(negedge ref_clk);
    bus.ioWr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(negedge ref_clk);
    bus.addr = a;
    #1 `CHK(n, e, rdata)
  endtask
  task automatic tk();
    @(negedge ref_clk);
    tick = 1'b1;
    #1 m = cMatch;
    @(negedge ref_clk);
    tick = 1'b0;
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] ofs[7] = '{8'h20, 8'h30, 8'h31, 8'h32, 8'h33, 8'h36, 8'h37};
    foreach (ofs[i]) rd(ofs[i], 8'h00, "reset value");
    bus.dataSpace = 1'b1;
    wr(8'h52, 8'h5A);
    rd(8'h52, 8'h5A, "data space counter");
    bus.dataSpace = 1'b0;
    rd(8'h32, 8'h5A, "io counter");
    wr(8'h21, 8'hFF);
    rd(8'h21, 8'h00, "unmapped");
  endtask
  task automatic t_match();
    wr(8'h31, 8'h10);
    wr(8'h32, 8'h10);
    tk();
    `CHK("blocked match", 1'b0, m)
    wr(8'h32, 8'h0F);
    tk();
    tk();
    `CHK("match", 1'b1, m)
    rd(8'h36, 8'h02, "compare flag");
    wr(8'h37, 8'h03);
    gie = 1'b1;
    #1 `CHK("compare irq", 1'b1, cIrq)
    wr(8'h36, 8'h02);
    #1 `CHK("compare w1c", 1'b0, cIrq)
    wr(8'h32, 8'hFF);
    tk();
    #1 `CHK("overflow irq", 1'b1, oIrq)
    gie = 1'b0;
    #1 `CHK("irq gated", 1'b0, oIrq)
    @(negedge ref_clk) oAck = 1'b1;
    @(negedge ref_clk) oAck = 1'b0;
    rd(8'h36, 8'h00, "overflow vector clear");
    wr(8'h32, 8'h0F);
    tk();
    tk();
    gie = 1'b1;
    #1 `CHK("compare irq again", 1'b1, cIrq)
    @(negedge ref_clk) cAck = 1'b1;
    @(negedge ref_clk) cAck = 1'b0;
    rd(8'h36, 8'h00, "compare vector clear");
    gie = 1'b0;
  endtask
  task automatic t_phase();
    wr(8'h33, 8'h40);
    wr(8'h32, 8'hFE);
    tk();
    tk();
    rd(8'h36, 8'h00, "no overflow at top");
    repeat (255) tk();
    // Down-count passes the compare value too, so both flags are up
    rd(8'h36, 8'h03, "overflow at bottom");
    `CHK("count up again", 8'h01, cnt)
    wr(8'h36, 8'h03);
    wr(8'h33, 8'h00);
  endtask
  task automatic t_async();
    wr(8'h30, 8'h08);
    rd(8'h30, 8'h08, "async select");
    wr(8'h32, 8'h33);
    rd(8'h30, 8'h0C, "counter busy");
    wr(8'h31, 8'h44);
    wr(8'h33, 8'h00);
    repeat (20) @(negedge ref_clk);
    rd(8'h30, 8'h0F, "busy flags held");
    // Crystal runs only here; no writes while busy
    repeat (40)
    begin
      repeat (3) @(negedge ref_clk);
      osc = ~osc;
    end
    osc = 1'b0;
    rd(8'h30, 8'h08, "busy flags cleared");
    rd(8'h31, 8'h44, "compare temporary");
    // First crystal edge loads, the other 19 count
    `CHK("async counter", 8'h46, cnt)
    wr(8'h20, 8'h02);
    rd(8'h20, 8'h02, "psr async read");
    wr(8'h30, 8'h00);
  endtask
  task automatic t_sfio();
    wr(8'h20, 8'h02);
    #1 `CHK("psr set", 1'b1, psrOut)
    rd(8'h20, 8'h00, "psr reads zero");
    repeat (5) @(negedge ref_clk);
    `CHK("psr self clear", 1'b0, psrOut)
    wr(8'h20, 8'h82);
    repeat (10) @(negedge ref_clk);
    `CHK("psr held", 1'b1, psrOut)
    `CHK("halted", 1'b1, halted)
    rd(8'h20, 8'h80, "halt bit");
    wr(8'h20, 8'h00);
    `CHK("psr released", 1'b0, psrOut)
  endtask
  initial
  begin
    bus = '0;
    {osc, tick, gie, cAck, oAck} = '0;
    srst = 1'b1;
    repeat (20) @(negedge ref_clk);
    srst = 1'b0;
    t_reset();
    t_match();
    t_phase();
    t_async();
    t_sfio();
    endSim();
  end
  // Whole run is under a thousand cycles
  initial
  begin
    #2000000;
    errors++;
    endSim();
  end
endmodule
